// [inc/cpc_defines.svh]
// Constants for the core performance counter block
`ifndef CPC_DEFINES_SVH
`define CPC_DEFINES_SVH

// Coprocessor register number and selects
`define CPC_REG_NUM 5'h19
`define CPC_SEL_CTL0 3'h0
`define CPC_SEL_CNT0 3'h1
`define CPC_SEL_CTL1 3'h2
`define CPC_SEL_CNT1 3'h3

// Control and count register reset values
`define CPC_CTL0_RESET 64'h0000_000C_0000_0000
`define CPC_CTL1_RESET 64'h0000_0000_4000_0000
`define CPC_CNT_RESET 64'h0000_0000_0000_0000

// Read data, flag clear and count step values
`define CPC_DATA_ZERO 64'h0000_0000_0000_0000
`define CPC_BIT_CLEAR 1'h0
`define CPC_CNT_STEP 64'h0000_0000_0000_0001

// Control register field positions
`define CPC_CTL_M_BIT 31
`define CPC_CTL_W_BIT 30
`define CPC_CTL_EVT_HI 8
`define CPC_CTL_EVT_LO 5
`define CPC_CTL_U_BIT 3
`define CPC_CTL_S_BIT 2
`define CPC_CTL_K_BIT 1
`define CPC_CTL_EXL_BIT 0

// Read-only flag values
`define CPC_CTL0_M_VAL 1'h1
`define CPC_CTL1_M_VAL 1'h0
`define CPC_CTL_W_VAL 1'h1

// Counter top bit and privilege codes
`define CPC_CNT_TOP_BIT 63
`define CPC_KSU_KERNEL 2'h0
`define CPC_KSU_SUPER 2'h1
`define CPC_KSU_USER 2'h2

`endif

// [inc/cpc_pkg.sv]
// Types shared by the core performance counter block
package cpc_pkg;

   // Processor mode seen by the qualifiers
   typedef struct packed {
      logic [1:0] privilege_field;
      logic exception_level_flag;
      logic error_level_flag;
   } cpc_mode_type;

   // Coprocessor register access request
   typedef struct packed {
      logic read;
      logic write;
      logic [4:0] reg_num;
      logic [2:0] sel;
      logic [63:0] wdata;
   } cpc_cop_req_type;

   // Counter 0 events, codes 15 down to 1; code 0 is the cycle
   typedef struct packed {
      logic internal_exception;
      logic exception;
      logic tlb_refill;
      logic cop_queue_full;
      logic reorder_queue_full;
      logic integer_queue_full;
      logic memory_read;
      logic history_predict;
      logic float1_issue;
      logic memory_issue;
      logic integer1_issue;
      logic icache_miss;
      logic return_jump;
      logic register_jump;
      logic branch;
   } cpc_events0_type;

   // Counter 1 events, codes 15 down to 0
   typedef struct packed {
      logic cop_queue_forward;
      logic load_misspec;
      logic any_exception;
      logic itlb_miss;
      logic branch_queue_full;
      logic float_queue_full;
      logic memory_write;
      logic history_mispredict;
      logic uncached_access;
      logic float2_issue;
      logic integer2_issue;
      logic dcache_miss;
      logic return_mispredict;
      logic register_mispredict;
      logic branch_mispredict;
      logic commit;
   } cpc_events1_type;

endpackage

// [core/cpc_qualify.sv]
// Privilege-level gate for one counter
`timescale 1ns/1ps
`default_nettype none
module cpc_qualify
(
   input wire logic kernel_en_in,
   input wire logic super_en_in,
   input wire logic user_en_in,
   input wire logic exl_en_in,
   input wire cpc_pkg::cpc_mode_type mode_in,
   output logic count_ok_out
);
`include "cpc_defines.svh"

   wire logic normal_mode;
   wire logic in_kernel;
   wire logic in_super;
   wire logic in_user;
   wire logic in_exl;

   assign normal_mode = !mode_in.exception_level_flag && !mode_in.error_level_flag;
   assign in_kernel = kernel_en_in && normal_mode && (mode_in.privilege_field == `CPC_KSU_KERNEL);
   assign in_super = super_en_in && normal_mode && (mode_in.privilege_field == `CPC_KSU_SUPER);
   assign in_user = user_en_in && normal_mode && (mode_in.privilege_field == `CPC_KSU_USER);
   // Exception level counts whatever the privilege field says
   assign in_exl = exl_en_in && mode_in.exception_level_flag && !mode_in.error_level_flag;
   assign count_ok_out = in_kernel || in_super || in_user || in_exl;

endmodule
`default_nettype wire

// [core/cpc_event_mux.sv]
// Sixteen-way event selector for one counter
`timescale 1ns/1ps
`default_nettype none
module cpc_event_mux
(
   input wire logic [15:0] events_in,
   input wire logic [3:0] code_in,
   output logic event_out
);

   function automatic logic pick_event(input logic [15:0] events, input logic [3:0] code);
      pick_event = events[code];
   endfunction

   assign event_out = pick_event(events_in, code_in);

endmodule
`default_nettype wire

// [core/cpc_top.sv]
// Core performance counters: two control/count pairs on coprocessor register 25
//
// Notes on behaviour
// - Register 25 selects 0..3: control 0, count 0, control 1, count 1.
// - Reset loads control 0 with its documented initial value.
// - Reset loads control 1 with its documented initial value.
// - Count registers are 64-bit, read/write, plus one per qualified event.
// - Both counters select and count events fully independently.
// - Top bit becoming one raises overflow interrupt and cause flag.
// - Read-only M flag says whether another counter pair follows.
// - Read-only W flag gives count width: zero 32, one 64.
// - Kernel enable counts at privilege 0 with both level flags clear.
// - Supervisor enable counts at privilege 1 with both level flags clear.
// - User enable counts at privilege 2 with both level flags clear.
// - Counter 0 codes 0000..0111: cycles through first floating unit issues.
// - Counter 0 codes 1000..1111: predictions through internal exceptions.
// - Counter 1 codes 0000..0111: commits through uncached accesses.
// - Counter 1 codes 1000..1111: mispredictions through queue load forwards.
`timescale 1ns/1ps
`default_nettype none
module cpc_top
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire cpc_pkg::cpc_cop_req_type cop_req_in,
   input wire cpc_pkg::cpc_mode_type mode_in,
   input wire cpc_pkg::cpc_events0_type events0_in,
   input wire cpc_pkg::cpc_events1_type events1_in,
   output logic [63:0] rdata_out,
   output logic rvalid_out,
   output logic overflow_irq_out,
   output logic overflow_flag_set_out
);
`include "cpc_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Register decode

   function automatic logic hits_sel(input cpc_pkg::cpc_cop_req_type req, input logic [2:0] sel);
      hits_sel = (req.reg_num == `CPC_REG_NUM) && (req.sel == sel);
   endfunction

   wire logic wr_ctl0;
   wire logic wr_cnt0;
   wire logic wr_ctl1;
   wire logic wr_cnt1;
   wire logic rd_ctl0;
   wire logic rd_cnt0;
   wire logic rd_ctl1;
   wire logic rd_cnt1;

   // Read and write may share a cycle; the read returns the old value
   assign wr_ctl0 = cop_req_in.write && hits_sel(cop_req_in, `CPC_SEL_CTL0);
   assign wr_cnt0 = cop_req_in.write && hits_sel(cop_req_in, `CPC_SEL_CNT0);
   assign wr_ctl1 = cop_req_in.write && hits_sel(cop_req_in, `CPC_SEL_CTL1);
   assign wr_cnt1 = cop_req_in.write && hits_sel(cop_req_in, `CPC_SEL_CNT1);
   assign rd_ctl0 = cop_req_in.read && hits_sel(cop_req_in, `CPC_SEL_CTL0);
   assign rd_cnt0 = cop_req_in.read && hits_sel(cop_req_in, `CPC_SEL_CNT0);
   assign rd_ctl1 = cop_req_in.read && hits_sel(cop_req_in, `CPC_SEL_CTL1);
   assign rd_cnt1 = cop_req_in.read && hits_sel(cop_req_in, `CPC_SEL_CNT1);

////////////////////////////////////////////////////////////////////////////////
// Control registers

   logic [63:0] event_control_0_reg;
   logic [63:0] event_control_1_reg;
   logic [63:0] event_control_0_next;
   logic [63:0] event_control_1_next;

   // Whole word stored; spare bits read back as written
   assign event_control_0_next = wr_ctl0 ? cop_req_in.wdata : event_control_0_reg;
   assign event_control_1_next = wr_ctl1 ? cop_req_in.wdata : event_control_1_reg;

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         event_control_0_reg <= `CPC_CTL0_RESET;
      else
         event_control_0_reg <= event_control_0_next;
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         event_control_1_reg <= `CPC_CTL1_RESET;
      else
         event_control_1_reg <= event_control_1_next;
   end

   // Read view: M and W are wired, whatever was written there
   function automatic logic [63:0] ctl_view(input logic [63:0] stored, input logic more);
      logic [63:0] view;
      view = stored;
      view[`CPC_CTL_M_BIT] = more;
      view[`CPC_CTL_W_BIT] = `CPC_CTL_W_VAL;
      ctl_view = view;
   endfunction

   wire logic [63:0] ctl0_view;
   wire logic [63:0] ctl1_view;

   assign ctl0_view = ctl_view(event_control_0_reg, `CPC_CTL0_M_VAL);
   assign ctl1_view = ctl_view(event_control_1_reg, `CPC_CTL1_M_VAL);

////////////////////////////////////////////////////////////////////////////////
// Control fields

   wire logic kernel_en0;
   wire logic super_en0;
   wire logic user_en0;
   wire logic exl_en0;
   wire logic kernel_en1;
   wire logic super_en1;
   wire logic user_en1;
   wire logic exl_en1;

   // Gates read the stored bits; only the read view overlays M and W
   assign kernel_en0 = event_control_0_reg[`CPC_CTL_K_BIT];
   assign super_en0 = event_control_0_reg[`CPC_CTL_S_BIT];
   assign user_en0 = event_control_0_reg[`CPC_CTL_U_BIT];
   assign exl_en0 = event_control_0_reg[`CPC_CTL_EXL_BIT];
   assign kernel_en1 = event_control_1_reg[`CPC_CTL_K_BIT];
   assign super_en1 = event_control_1_reg[`CPC_CTL_S_BIT];
   assign user_en1 = event_control_1_reg[`CPC_CTL_U_BIT];
   assign exl_en1 = event_control_1_reg[`CPC_CTL_EXL_BIT];

////////////////////////////////////////////////////////////////////////////////
// Event selection

   wire logic [15:0] events0_vec;
   wire logic [15:0] events1_vec;
   wire logic [3:0] code0;
   wire logic [3:0] code1;
   wire logic event0_hit;
   wire logic event1_hit;

   // Code 0 of counter 0 is the core clock itself
   assign events0_vec = {events0_in, 1'h1};
   assign events1_vec = events1_in;
   assign code0 = event_control_0_reg[`CPC_CTL_EVT_HI:`CPC_CTL_EVT_LO];
   assign code1 = event_control_1_reg[`CPC_CTL_EVT_HI:`CPC_CTL_EVT_LO];

   cpc_event_mux mux0
   (
      .events_in(events0_vec),
      .code_in(code0),
      .event_out(event0_hit)
   );

   cpc_event_mux mux1
   (
      .events_in(events1_vec),
      .code_in(code1),
      .event_out(event1_hit)
   );

////////////////////////////////////////////////////////////////////////////////
// Privilege qualification

   wire logic ok0;
   wire logic ok1;

   cpc_qualify qual0
   (
      .kernel_en_in(kernel_en0),
      .super_en_in(super_en0),
      .user_en_in(user_en0),
      .exl_en_in(exl_en0),
      .mode_in(mode_in),
      .count_ok_out(ok0)
   );

   cpc_qualify qual1
   (
      .kernel_en_in(kernel_en1),
      .super_en_in(super_en1),
      .user_en_in(user_en1),
      .exl_en_in(exl_en1),
      .mode_in(mode_in),
      .count_ok_out(ok1)
   );

////////////////////////////////////////////////////////////////////////////////
// Count registers

   logic [63:0] event_count_0_reg;
   logic [63:0] event_count_1_reg;
   logic [63:0] event_count_0_next;
   logic [63:0] event_count_1_next;
   wire logic inc0;
   wire logic inc1;

   // Plain adder: all ones wraps round to zero
   function automatic logic [63:0] count_step(input logic [63:0] cur, input logic wr,
                                              input logic [63:0] wdata, input logic inc);
      // Software write wins over a same-cycle event
      if (wr)
         count_step = wdata;
      else if (inc)
         count_step = cur + `CPC_CNT_STEP;
      else
         count_step = cur;
   endfunction

   assign inc0 = event0_hit && ok0;
   assign inc1 = event1_hit && ok1;
   // Each counter sees only its own event and gate
   assign event_count_0_next = count_step(event_count_0_reg, wr_cnt0, cop_req_in.wdata, inc0);
   assign event_count_1_next = count_step(event_count_1_reg, wr_cnt1, cop_req_in.wdata, inc1);

   // Counts clear on reset so the first read is known
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         event_count_0_reg <= `CPC_CNT_RESET;
      else
         event_count_0_reg <= event_count_0_next;
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         event_count_1_reg <= `CPC_CNT_RESET;
      else
         event_count_1_reg <= event_count_1_next;
   end

////////////////////////////////////////////////////////////////////////////////
// Overflow

   wire logic top0_now;
   wire logic top1_now;
   wire logic top0_next;
   wire logic top1_next;
   wire logic rise0;
   wire logic rise1;
   wire logic irq_next;
   wire logic flag_next;

   assign top0_now = event_count_0_reg[`CPC_CNT_TOP_BIT];
   assign top1_now = event_count_1_reg[`CPC_CNT_TOP_BIT];
   assign top0_next = event_count_0_next[`CPC_CNT_TOP_BIT];
   assign top1_next = event_count_1_next[`CPC_CNT_TOP_BIT];
   // Any 0 to 1 change of the top bit, by count or by write
   assign rise0 = !top0_now && top0_next;
   assign rise1 = !top1_now && top1_next;
   assign flag_next = rise0 || rise1;
   // Interrupt holds while either top bit stays set; software clears it by rewriting
   assign irq_next = top0_next || top1_next;

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         overflow_irq_out <= `CPC_BIT_CLEAR;
      else
         overflow_irq_out <= irq_next;
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         overflow_flag_set_out <= `CPC_BIT_CLEAR;
      else
         overflow_flag_set_out <= flag_next;
   end

////////////////////////////////////////////////////////////////////////////////
// Read port

   wire logic [63:0] ctl0_part;
   wire logic [63:0] cnt0_part;
   wire logic [63:0] ctl1_part;
   wire logic [63:0] cnt1_part;
   wire logic [63:0] rdata_next;

   // Selects are exclusive, so the OR of the gated parts is the mux
   // Unmapped reads return zero; values are those before this cycle's write
   assign ctl0_part = rd_ctl0 ? ctl0_view : `CPC_DATA_ZERO;
   assign cnt0_part = rd_cnt0 ? event_count_0_reg : `CPC_DATA_ZERO;
   assign ctl1_part = rd_ctl1 ? ctl1_view : `CPC_DATA_ZERO;
   assign cnt1_part = rd_cnt1 ? event_count_1_reg : `CPC_DATA_ZERO;
   assign rdata_next = ctl0_part | cnt0_part | ctl1_part | cnt1_part;

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         rdata_out <= `CPC_DATA_ZERO;
      else
         rdata_out <= rdata_next;
   end

   // Any read is answered, mapped or not, so software never waits on a hole
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         rvalid_out <= `CPC_BIT_CLEAR;
      else
         rvalid_out <= cop_req_in.read;
   end

endmodule
`default_nettype wire

// [bench/cpc_top_sva.sv]
// Port-level assertions for the performance counter block
`timescale 1ns/1ps
`default_nettype none
module cpc_top_sva
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire cpc_pkg::cpc_cop_req_type cop_req_in,
   input wire logic [63:0] rdata_out,
   input wire logic rvalid_out,
   input wire logic overflow_irq_out,
   input wire logic overflow_flag_set_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   wire logic hit_w = cop_req_in.read && cop_req_in.reg_num == 5'h19;
   ////////////////////////////////////////////////////////////////
   read_answer_a: assert property (cop_req_in.read |=> rvalid_out)
      else $error("read not answered");
   idle_quiet_a: assert property (!cop_req_in.read |=> !rvalid_out && rdata_out == 64'h0)
      else $error("data without read");
   unmapped_zero_a: assert property (cop_req_in.read && cop_req_in.reg_num != 5'h19 |=> rdata_out == 64'h0)
      else $error("unmapped register gave data");
   high_sel_a: assert property (hit_w && cop_req_in.sel > 3'h3 ##1 1'b1 |-> rdata_out == 64'h0)
      else $error("unmapped select gave data");
   ctl0_flags_a: assert property (hit_w && cop_req_in.sel == 3'h0 |=> rdata_out[31:30] == 2'h3)
      else $error("control 0 flags wrong");
   ctl1_flags_a: assert property (hit_w && cop_req_in.sel == 3'h2 |=> rdata_out[31:30] == 2'h1)
      else $error("control 1 flags wrong");
   irq_rise_a: assert property ($rose(overflow_irq_out) |-> overflow_flag_set_out)
      else $error("interrupt rose without flag");
   flag_irq_a: assert property (overflow_flag_set_out |-> overflow_irq_out)
      else $error("flag without interrupt");
   ////////////////////////////////////////////////////////////////
   cover property (hit_w && cop_req_in.sel == 3'h1);
   cover property (overflow_flag_set_out);
   cover property (cop_req_in.write && cop_req_in.sel == 3'h3);
endmodule
bind cpc_top cpc_top_sva chk (.clk_in(clk_in), .reset_in(reset_in), .cop_req_in(cop_req_in),
   .rdata_out(rdata_out), .rvalid_out(rvalid_out), .overflow_irq_out(overflow_irq_out),
   .overflow_flag_set_out(overflow_flag_set_out));
`default_nettype wire

// [bench/cpc_pipe_model.sv]
// Pipeline event source: one-hot event pulses for either counter
`timescale 1ns/1ps
`default_nettype none
module cpc_pipe_model
(
   input wire logic go0_in,
   input wire logic go1_in,
   input wire logic [3:0] code0_in,
   input wire logic [3:0] code1_in,
   output var cpc_pkg::cpc_events0_type events0_out,
   output var cpc_pkg::cpc_events1_type events1_out
);
   // Idle pipeline shows no events at all
   wire logic [15:0] hot0_w = go0_in ? 16'h0001 << code0_in : 16'h0000;
   wire logic [15:0] hot1_w = go1_in ? 16'h0001 << code1_in : 16'h0000;
   // Code 0 of counter 0 is the cycle itself, so it has no line
   assign events0_out = hot0_w[15:1];
   assign events1_out = hot1_w;
endmodule
`default_nettype wire

// [bench/cpc_top_bench.sv]
// Self-checking bench for the performance counter block
`timescale 1ns/1ps
`default_nettype none
module cpc_top_bench;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   cpc_pkg::cpc_cop_req_type req = '0;
   cpc_pkg::cpc_mode_type mode = '0;
   logic go0 = 1'b0;
   logic go1 = 1'b0;
   logic [3:0] code = 4'h0;
   cpc_pkg::cpc_events0_type ev0;
   cpc_pkg::cpc_events1_type ev1;
   logic [63:0] rdata;
   logic rvalid;
   logic irq;
   logic flag;
   logic [63:0] got;
   int fails = 0;
   int total_checks = 0;
   int flag_seen = 0;
   int ok;
   always #2 clk_in = ~clk_in;
   cpc_top uut (.clk_in(clk_in), .reset_in(reset_in), .cop_req_in(req), .mode_in(mode), .events0_in(ev0),
      .events1_in(ev1), .rdata_out(rdata), .rvalid_out(rvalid), .overflow_irq_out(irq),
      .overflow_flag_set_out(flag));
   cpc_pipe_model partner (.go0_in(go0), .go1_in(go1), .code0_in(code), .code1_in(code),
      .events0_out(ev0), .events1_out(ev1));
   always @(posedge clk_in) if (flag === 1'b1) flag_seen++;
   ////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [63:0] exp, input logic [63:0] seen);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic check_bit(input string name, input logic exp, input logic seen);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected %s expected %b seen %b", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [2:0] sel, input logic [63:0] data);
      @(negedge clk_in);
      req = '{read: 1'b0, write: 1'b1, reg_num: 5'h19, sel: sel, wdata: data};
      @(negedge clk_in);
      req.write = 1'b0;
   endtask
   task automatic rd(input logic [4:0] num, input logic [2:0] sel);
      @(negedge clk_in);
      req = '{read: 1'b1, write: 1'b0, reg_num: num, sel: sel, wdata: 64'h0};
      @(negedge clk_in);
      req.read = 1'b0;
      got = rdata;
      check_bit("rvalid", 1'h1, rvalid);
   endtask
   // Holds the event for n rising edges
   task automatic fire(input logic which, input logic [3:0] c, input int n);
      @(negedge clk_in);
      code = c;
      go0 = !which;
      go1 = which;
      repeat (n) @(negedge clk_in);
      go0 = 1'b0;
      go1 = 1'b0;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      #100000;
      fails++;
      stop_test();
   end
   initial
   begin
      repeat (3) @(negedge clk_in);
      reset_in = 1'b0;
      rd(5'h19, 3'h0);
      check("control 0", 64'h0000_000C_C000_0000, got);
      rd(5'h19, 3'h2);
      check("control 1", 64'h0000_0000_4000_0000, got);
      rd(5'h18, 3'h1);
      check("unmapped reg", 64'h0, got);
      wr(3'h5, 64'hFFFF_FFFF_FFFF_FFFF);
      rd(5'h19, 3'h5);
      check("unmapped sel", 64'h0, got);
      wr(3'h0, 64'h0);
      rd(5'h19, 3'h0);
      check("control 0 flags", 64'h0000_0000_C000_0000, got);
      // Cycle count: gate closed by exception level during setup
      mode = cpc_pkg::cpc_mode_type'(4'h2);
      wr(3'h0, 64'h2);
      wr(3'h1, 64'h0);
      @(negedge clk_in);
      mode = cpc_pkg::cpc_mode_type'(4'h0);
      repeat (4) @(negedge clk_in);
      mode = cpc_pkg::cpc_mode_type'(4'h2);
      rd(5'h19, 3'h1);
      check("cycle count", 64'h4, got);
      mode = cpc_pkg::cpc_mode_type'(4'h0);
      for (int c = 0; c < 16; c++)
      begin
         wr(3'h0, (64'(c) << 5) | (c != 0 ? 64'h2 : 64'h0));
         wr(3'h2, (64'(c) << 5) | 64'h2);
         wr(3'h1, 64'h0);
         wr(3'h3, 64'h0);
         fire(1'b0, c[3:0], 3);
         fire(1'b1, c[3:0], 2);
         rd(5'h19, 3'h1);
         check("count 0 event", c != 0 ? 64'h3 : 64'h0, got);
         rd(5'h19, 3'h3);
         check("count 1 event", 64'h2, got);
      end
      for (int b = 0; b < 4; b++)
         for (int m = 0; m < 16; m++)
         begin
            mode = cpc_pkg::cpc_mode_type'(m[3:0]);
            ok = ((b == 1 && m[3:2] == 0) || (b == 2 && m[3:2] == 1) || (b == 3 && m[3:2] == 2)) && m[1:0] == 0;
            ok = ok || (b == 0 && m[1:0] == 2'h2);
            wr(3'h2, 64'h1 << b);
            wr(3'h3, 64'h0);
            fire(1'b1, 4'h0, 2);
            rd(5'h19, 3'h3);
            check("count 1 gate", ok ? 64'h2 : 64'h0, got);
         end
      mode = cpc_pkg::cpc_mode_type'(4'h0);
      wr(3'h3, 64'hA5A5_5A5A_0F0F_F0F0);
      rd(5'h19, 3'h3);
      check("count 1 rw", 64'hA5A5_5A5A_0F0F_F0F0, got);
      // Count 1 top bit must drop, or it alone would hold the interrupt up
      wr(3'h3, 64'h0);
      wr(3'h0, 64'h22);
      wr(3'h1, 64'h7FFF_FFFF_FFFF_FFFF);
      check_bit("irq before", 1'h0, irq);
      flag_seen = 0;
      fire(1'b0, 4'h1, 1);
      rd(5'h19, 3'h1);
      check("count 0 top", 64'h8000_0000_0000_0000, got);
      check_bit("irq", 1'h1, irq);
      check("flag pulses", 64'h1, 64'(flag_seen));
      wr(3'h1, 64'h0);
      rd(5'h19, 3'h1);
      check_bit("irq cleared", 1'h0, irq);
      stop_test();
   end
endmodule
`default_nettype wire
